// >>> pkg/idp_regs.vh
`ifndef IDP_REGS_VH
`define IDP_REGS_VH
// =====================================================================
// register offsets (byte addresses on the register bus)
`define IDP_OFF_WIN0        12'h000
`define IDP_OFF_PTR0        12'h004
`define IDP_OFF_WIN1        12'h008
`define IDP_OFF_PTR1        12'h00c
`define IDP_OFF_PPTR_LO     12'h010
`define IDP_OFF_PPTR_HI     12'h014
`define IDP_OFF_LATCH_LO    12'h018
`define IDP_OFF_LATCH_HI    12'h01c
`define IDP_OFF_ALU_STATUS  12'h020
`define IDP_OFF_BANK_SEL    12'h024
// =====================================================================
// data addresses of the window locations themselves
`define IDP_ADDR_WIN0       8'h00
`define IDP_ADDR_WIN1       8'h08
// =====================================================================
// mode field and zero flag positions in the alu status register
`define IDP_MODE0_LSB       0
`define IDP_MODE1_LSB       2
`define IDP_ZERO_BIT        4
// mode encodings
`define IDP_MODE_DEC        2'b00
`define IDP_MODE_INC        2'b01
// reset values and the zero read word
`define IDP_RST_BYTE        8'h00
`define IDP_RST_WORD        16'h0000
`define IDP_RST_STATUS      8'h0f
`define IDP_RST_BANK        4'h0
`define IDP_ZERO_DATA       32'h00000000
`endif

// >>> verilog/idp_pointer_unit.v
// =====================================================================
// Overview of operation
// [R01] window registers hold nothing; accesses go to memory at paired pointer
// [R02] each pointer is eight bits, reaching all 256 data bytes
// [R03] banked targets use the current bank select value
// [R04] indirect read of a window location returns zero, sets zero flag
// [R05] indirect write of a window location is a no-operation, flags kept
// [R06] pointer at zero: read gives zero plus zero flag, write discarded
// [R07] two mode bits per pointer: decrement, increment or hold after access
// [R08] upper mode pair in alu status drives pointer 1, lower pair pointer 0
// [R09] pointer stepping never touches any alu status flag
// [R10] window moves finish in one cycle
// [R11] two bytes form a 16-bit program memory pointer for table instructions
// [R12] 16-bit table latch, high and low bytes mapped on the bus, buffers table words
// [R13] mode 00 decrements, 01 increments, 1x holds; pointers wrap modulo 256
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "idp_regs.vh"
module idp_pointer_unit #(
   parameter BANK_W = 4
) (
   input  wire        clock,       // core clock
   input  wire        rst_n,       // async reset, active low
   input  wire        clk_en,      // freezes all state while low
   input  wire        psel,        // apb select
   input  wire        penable,     // apb access phase
   input  wire        pwrite,      // apb direction
   input  wire [11:0] paddr,       // apb byte address
   input  wire [31:0] pwdata,      // apb write data
   output wire        pready,      // apb ready
   output reg  [31:0] prdata,      // apb read data
   output wire        pslverr,     // apb error
   output wire [7:0]  mem_addr,    // data memory address
   output wire [BANK_W-1:0] mem_bank, // data memory bank
   output wire        mem_we,      // data memory write strobe
   output wire [7:0]  mem_wdata,   // data memory write data
   input  wire [7:0]  mem_rdata,   // data memory read data, same cycle
   output wire        mem_re,      // data memory read strobe
   input  wire        tbl_rd,      // table read: latch takes program word
   input  wire        tbl_wt,      // table write: latch word goes out
   input  wire [15:0] prog_rdata,  // program word read at pointer
   input  wire        tbl_inc,     // step program pointer after table op
   output wire [15:0] prog_addr,   // program memory word address
   output reg  [15:0] prog_wdata,  // program word to write
   output reg         prog_we      // program write strobe
);
   // =====================================================================
   // state
   reg [7:0]        ptr0;
   reg [7:0]        ptr1;
   reg [7:0]        pptr_lo;
   reg [7:0]        pptr_hi;
   reg [15:0]       latch;
   reg [7:0]        alu_status;
   reg [BANK_W-1:0] bank_sel;

   // =====================================================================
   // bus decode
   wire access   = psel & penable;
   wire wr       = access & pwrite & clk_en;
   wire sel_w0   = (paddr == `IDP_OFF_WIN0);
   wire sel_w1   = (paddr == `IDP_OFF_WIN1);
   wire sel_win  = sel_w0 | sel_w1;
   wire mapped   = sel_win | (paddr == `IDP_OFF_PTR0) | (paddr == `IDP_OFF_PTR1) |
                   (paddr == `IDP_OFF_PPTR_LO) | (paddr == `IDP_OFF_PPTR_HI) |
                   (paddr == `IDP_OFF_LATCH_LO) | (paddr == `IDP_OFF_LATCH_HI) |
                   (paddr == `IDP_OFF_ALU_STATUS) | (paddr == `IDP_OFF_BANK_SEL);

   // single cycle answer for every access
   assign pready  = 1'b1;                                        // see [R10]
   assign pslverr = access & ~mapped;

   // =====================================================================
   // indirect access path
   wire [7:0] cur_ptr  = sel_w1 ? ptr1 : ptr0;                   // see [R01]
   wire       tgt_win  = (cur_ptr == `IDP_ADDR_WIN0) | (cur_ptr == `IDP_ADDR_WIN1); // see [R04]
   wire       win_acc  = access & sel_win & clk_en;
   wire [1:0] mode0    = alu_status[`IDP_MODE0_LSB+1:`IDP_MODE0_LSB]; // see [R08]
   wire [1:0] mode1    = alu_status[`IDP_MODE1_LSB+1:`IDP_MODE1_LSB]; // see [R08]

   // pointer zero is window 0, so one test covers both cases
   assign mem_addr  = cur_ptr;                                   // see [R02]
   assign mem_bank  = bank_sel;                                  // see [R03]
   assign mem_we    = win_acc & pwrite & ~tgt_win;               // see [R05] see [R06]
   assign mem_re    = win_acc & ~pwrite & ~tgt_win;
   assign mem_wdata = pwdata[7:0];

   // next pointer after a window access
   function [7:0] step;
      input [7:0] p;
      input [1:0] m;
      begin
         if (m == `IDP_MODE_DEC) begin
            step = p - 8'h01;                                    // see [R13]
         end else if (m == `IDP_MODE_INC) begin
            step = p + 8'h01;                                    // see [R13]
         end else begin
            step = p;
         end
      end
   endfunction

   // =====================================================================
   // program side
   assign prog_addr = {pptr_hi, pptr_lo};                        // see [R11]
   wire [15:0] next_pptr = prog_addr + 16'h0001;

   // =====================================================================
   // read mux
   always @* begin
      prdata = `IDP_ZERO_DATA;
      if (sel_win) begin
         prdata = tgt_win ? `IDP_ZERO_DATA : {24'h000000, mem_rdata}; // see [R04] see [R06]
      end else if (paddr == `IDP_OFF_PTR0) begin
         prdata = {24'h000000, ptr0};
      end else if (paddr == `IDP_OFF_PTR1) begin
         prdata = {24'h000000, ptr1};
      end else if (paddr == `IDP_OFF_PPTR_LO) begin
         prdata = {24'h000000, pptr_lo};
      end else if (paddr == `IDP_OFF_PPTR_HI) begin
         prdata = {24'h000000, pptr_hi};
      end else if (paddr == `IDP_OFF_LATCH_LO) begin
         prdata = {24'h000000, latch[7:0]};
      end else if (paddr == `IDP_OFF_LATCH_HI) begin
         prdata = {24'h000000, latch[15:8]};
      end else if (paddr == `IDP_OFF_ALU_STATUS) begin
         prdata = {24'h000000, alu_status};
      end else if (paddr == `IDP_OFF_BANK_SEL) begin
         prdata = {{(32-BANK_W){1'b0}}, bank_sel};
      end
   end

   // =====================================================================
   // register updates
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ptr0       <= `IDP_RST_BYTE;
         ptr1       <= `IDP_RST_BYTE;
         pptr_lo    <= `IDP_RST_BYTE;
         pptr_hi    <= `IDP_RST_BYTE;
         latch      <= `IDP_RST_WORD;
         alu_status <= `IDP_RST_STATUS;
         bank_sel   <= `IDP_RST_BANK;
         prog_wdata <= `IDP_RST_WORD;
         prog_we    <= 1'b0;
      end else if (clk_en) begin
         prog_we <= 1'b0;
         // window access: step the paired pointer, flags untouched by the step
         if (win_acc) begin
            if (sel_w1) begin
               ptr1 <= step(ptr1, mode1);                        // see [R07] see [R09]
            end else begin
               ptr0 <= step(ptr0, mode0);                        // see [R07] see [R09]
            end
            // zero flag from every window read: set on a window location, else from read data
            if (!pwrite) begin
               alu_status[`IDP_ZERO_BIT] <= tgt_win ? 1'b1 : (mem_rdata == `IDP_RST_BYTE); // see [R04] see [R06]
            end
         end
         if (wr && (paddr == `IDP_OFF_PTR0)) begin
            ptr0 <= pwdata[7:0];
         end
         if (wr && (paddr == `IDP_OFF_PTR1)) begin
            ptr1 <= pwdata[7:0];
         end
         if (wr && (paddr == `IDP_OFF_ALU_STATUS)) begin
            alu_status <= pwdata[7:0];
         end
         if (wr && (paddr == `IDP_OFF_BANK_SEL)) begin
            bank_sel <= pwdata[BANK_W-1:0];
         end
         // table pointer: software write, else post-step after table op
         if (wr && (paddr == `IDP_OFF_PPTR_LO)) begin
            pptr_lo <= pwdata[7:0];
         end else if (wr && (paddr == `IDP_OFF_PPTR_HI)) begin
            pptr_hi <= pwdata[7:0];
         end else if ((tbl_rd | tbl_wt) && tbl_inc) begin
            pptr_lo <= next_pptr[7:0];                           // see [R11]
            pptr_hi <= next_pptr[15:8];
         end
         // table latch: program read wins over byte writes
         if (tbl_rd) begin
            latch <= prog_rdata;                                 // see [R12]
         end else begin
            if (wr && (paddr == `IDP_OFF_LATCH_LO)) begin
               latch[7:0] <= pwdata[7:0];                        // see [R12]
            end
            if (wr && (paddr == `IDP_OFF_LATCH_HI)) begin
               latch[15:8] <= pwdata[7:0];                       // see [R12]
            end
         end
         if (tbl_wt) begin
            prog_wdata <= latch;                                 // see [R12]
            prog_we    <= 1'b1;
         end
      end
   end
endmodule

// >>> dv/idp_pointer_chk.sv
`timescale 1ns/1ps
`include "idp_regs.vh"
module idp_pointer_chk #(
   parameter BANK_W = 4
) (
   input wire              clock,      // core clock
   input wire              rst_n,      // async reset
   input wire              clk_en,     // state enable
   input wire              psel,       // apb select
   input wire              penable,    // apb access
   input wire              pwrite,     // apb direction
   input wire [11:0]       paddr,      // apb address
   input wire [31:0]       pwdata,     // apb write data
   input wire              pready,     // apb ready
   input wire [31:0]       prdata,     // apb read data
   input wire [7:0]        mem_addr,   // memory address
   input wire [BANK_W-1:0] mem_bank,   // memory bank
   input wire              mem_we,     // memory write
   input wire [7:0]        mem_wdata,  // memory write data
   input wire [7:0]        mem_rdata,  // memory read data
   input wire              mem_re,     // memory read
   input wire              tbl_rd,     // table read
   input wire              tbl_wt,     // table write
   input wire [15:0]       prog_rdata, // program word in
   input wire              tbl_inc,    // pointer step
   input wire [15:0]       prog_addr,  // program address
   input wire              prog_we     // program write
);
   // ==========================================
   // access decode
   wire acc    = psel & penable;
   wire win    = acc & (paddr == `IDP_OFF_WIN0 | paddr == `IDP_OFF_WIN1);
   wire at_win = mem_addr == `IDP_ADDR_WIN0 | mem_addr == `IDP_ADDR_WIN1;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // latch load followed by a bus read of its low byte
   sequence latch_load_s;
      tbl_rd & clk_en ##1 !tbl_rd [*2] ##1 acc & !pwrite & paddr == `IDP_OFF_LATCH_LO;
   endsequence
   // ==========================================
   // properties
   zero_wait_a: assert property (psel |-> pready) else $error("ready low");
   rd_pass_a: assert property (win & !pwrite & !at_win & clk_en |-> mem_re && prdata == {24'h000000, mem_rdata})
      else $error("window read data wrong");
   self_rd_a: assert property (win & !pwrite & at_win |-> !mem_re && prdata == 32'h00000000)
      else $error("self read not zero");
   self_wr_a: assert property (win & pwrite & at_win |-> !mem_we) else $error("self write stored");
   wr_pass_a: assert property (win & pwrite & !at_win & clk_en |-> mem_we && mem_wdata == pwdata[7:0])
      else $error("window write lost");
   bank_sel_a: assert property (acc & pwrite & clk_en & paddr == `IDP_OFF_BANK_SEL
      |=> mem_bank == $past(pwdata[BANK_W-1:0])) else $error("bank not applied");
   pptr_step_a: assert property (tbl_rd & tbl_inc & clk_en & !(acc & pwrite)
      |=> prog_addr == $past(prog_addr) + 16'h0001) else $error("program pointer step");
   latch_load_a: assert property (latch_load_s |-> prdata[7:0] == $past(prog_rdata[7:0], 3))
      else $error("latch load wrong");
   tbl_we_a: assert property (tbl_wt & clk_en |=> prog_we) else $error("no program write");
endmodule
bind idp_pointer_unit idp_pointer_chk #(.BANK_W(BANK_W)) chk_u (.*);

// >>> dv/testbench.sv
`timescale 1ns/1ps
`include "idp_regs.vh"
module testbench;
   reg         clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg         tbl_rd = 1'b0, tbl_wt = 1'b0, tbl_inc = 1'b0, errv;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h00000000, rdv;
   reg  [15:0] prog_rdata = 16'h0000;
   reg  [7:0]  mem [0:255];
   wire        pready, pslverr, mem_we, mem_re, prog_we;
   wire [31:0] prdata;
   wire [7:0]  mem_addr, mem_wdata, mem_rdata;
   wire [3:0]  mem_bank;
   wire [15:0] prog_addr, prog_wdata;
   integer     err_count = 0, n_tests = 0, cyc = 0, i;
   idp_pointer_unit #(.BANK_W(4)) dut_u (.*);
   // ==========================================
   // clock, data memory and timeout
   initial begin
      forever #5 clock = ~clock;
   end
   assign mem_rdata = mem[mem_addr];
   always @(posedge clock) begin
      if (mem_we)
         mem[mem_addr] <= mem_wdata;
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_count = err_count + 1;
         $display("[ERR] %0t timeout", $time);
         close_out;
      end
   end
   // ==========================================
   // tasks
   task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
      begin
         @(posedge clock);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         // sample settled answer before the edge that completes the access
         @(negedge clock);
         while (pready !== 1'b1) begin
            @(posedge clock);
            @(negedge clock);
         end
         rdv = prdata;
         errv = pslverr;
         @(posedge clock);
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task chk(input reg [31:0] g, input reg [31:0] e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
         end
      end
   endtask
   task rd(input reg [11:0] a, input reg [31:0] e);
      begin
         apb(1'b0, a, 32'h00000000);
         chk(rdv, e);
      end
   endtask
   task close_out;
      begin
         if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   // ==========================================
   // main sequence
   initial begin
      for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'ha5;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd(`IDP_OFF_ALU_STATUS, 32'h0000000f);
      rd(`IDP_OFF_PTR1, 32'h00000000);
      rd(12'h3fc, 32'h00000000);
      chk({31'h0, errv}, 32'h00000001);
      apb(1'b1, `IDP_OFF_ALU_STATUS, 32'h00000001);
      apb(1'b1, `IDP_OFF_PTR0, 32'h000000ff);
      apb(1'b1, `IDP_OFF_PTR1, 32'h00000001);
      apb(1'b1, `IDP_OFF_WIN0, 32'h0000005a);
      @(negedge clock);
      chk({24'h0, mem[255]}, 32'h0000005a);
      rd(`IDP_OFF_PTR0, 32'h00000000);
      rd(`IDP_OFF_WIN1, 32'h000000a4);
      rd(`IDP_OFF_ALU_STATUS, 32'h00000001);
      rd(`IDP_OFF_WIN0, 32'h00000000);
      rd(`IDP_OFF_ALU_STATUS, 32'h00000011);
      apb(1'b1, `IDP_OFF_WIN1, 32'h00000077);
      @(negedge clock);
      chk({24'h0, mem[0]}, 32'h000000a5);
      rd(`IDP_OFF_ALU_STATUS, 32'h00000011);
      rd(`IDP_OFF_PTR1, 32'h000000ff);
      apb(1'b1, `IDP_OFF_ALU_STATUS, 32'h0000000f);
      apb(1'b1, `IDP_OFF_PTR0, 32'h00000008);
      rd(`IDP_OFF_WIN0, 32'h00000000);
      clk_en <= 1'b0;
      apb(1'b1, `IDP_OFF_PTR0, 32'h00000033);
      clk_en <= 1'b1;
      rd(`IDP_OFF_PTR0, 32'h00000008);
      apb(1'b1, `IDP_OFF_BANK_SEL, 32'h0000000a);
      @(negedge clock);
      chk({28'h0, mem_bank}, 32'h0000000a);
      apb(1'b1, `IDP_OFF_PPTR_LO, 32'h000000ff);
      apb(1'b1, `IDP_OFF_PPTR_HI, 32'h00000012);
      @(negedge clock);
      chk({16'h0, prog_addr}, 32'h000012ff);
      @(posedge clock);
      tbl_rd <= 1'b1;
      tbl_inc <= 1'b1;
      prog_rdata <= 16'hbeef;
      @(posedge clock);
      tbl_rd <= 1'b0;
      tbl_inc <= 1'b0;
      rd(`IDP_OFF_LATCH_LO, 32'h000000ef);
      rd(`IDP_OFF_LATCH_HI, 32'h000000be);
      @(negedge clock);
      chk({16'h0, prog_addr}, 32'h00001300);
      @(posedge clock);
      tbl_wt <= 1'b1;
      @(posedge clock);
      tbl_wt <= 1'b0;
      @(negedge clock);
      chk({15'h0, prog_we, prog_wdata}, 32'h0001beef);
      close_out;
   end
endmodule
